// ### inc/fpr_defines.svh
// Offsets, field positions, reset values and counts for the FIFO port control block.
// Assumes inclusion by bare name from every design file that needs a constant.
`ifndef FPR_DEFINES_SVH
`define FPR_DEFINES_SVH

// ****************************************
// Data path
// ****************************************
`define FPR_DATA_W       36
`define FPR_BYTE_W       9
`define FPR_BYTES        4
`define FPR_RST_EDGES    4

// ****************************************
// Register map
// ****************************************
`define FPR_ADDR_W       8
`define FPR_OFF_CTRL     8'h00
`define FPR_OFF_STATUS   8'h04
`define FPR_OFF_IRQ_ST   8'h08
`define FPR_OFF_IRQ_MASK 8'h0C
`define FPR_CTRL_SOFTRST 0
`define FPR_IRQ_W        3
`define FPR_IRQ_RSTDONE  0
`define FPR_IRQ_PERR_A   1
`define FPR_IRQ_PERR_B   2
`define FPR_RESP_OKAY    2'h0
`define FPR_RESP_SLVERR  2'h2

// ****************************************
// Flags after a completed reset: {b_to_a, a_to_b, full, empty, almost_empty, almost_full}
// ****************************************
`define FPR_FLAGS_RST    6'h31

`endif

// ### inc/fpr_pkg.sv
// Types shared by the FIFO port control block.
// Assumes nothing beyond a SystemVerilog compiler.
package fpr_pkg;

	typedef logic [35:0] fpr_word_t;

	typedef enum logic [1:0] {
		FPR_RS_IDLE,
		FPR_RS_ARMED,
		FPR_RS_DONE
	} fpr_rst_state_t;

endpackage : fpr_pkg

// ### inc/fpr_parity_if.sv
// Carrier between the port logic and one parity tree.
// Assumes the parity tree is purely combinational.
`timescale 1ns/1ps
interface fpr_parity_if;
	import fpr_pkg::*;
	fpr_word_t word_in;
	fpr_word_t word_out;
	logic      odd;
	logic      gen;
	logic      ok;
	modport unit (input word_in, input odd, input gen, output word_out, output ok);
	modport user (output word_in, output odd, output gen, input word_out, input ok);
endinterface : fpr_parity_if

// ### rtl/fpr_parity.sv
// One parity tree: checks a 36-bit word and optionally replaces each byte MSB with parity.
// Assumes the user drives all interface inputs every cycle.
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_parity
	import fpr_pkg::*;
#(
	parameter int BYTES = `FPR_BYTES
) (
	fpr_parity_if.unit pif
);
	localparam int BW = `FPR_BYTE_W;

	logic [BYTES-1:0] byte_ok;

	generate
		if (BYTES * BW != `FPR_DATA_W) begin : g_bad
			$error("fpr_parity: byte count does not fill the word");
		end
		for (genvar gi = 0; gi < BYTES; gi++) begin : g_byte
			wire par_bit = (^pif.word_in[gi*BW +: BW-1]) ^ pif.odd;
			assign pif.word_out[gi*BW +: BW-1] = pif.word_in[gi*BW +: BW-1];
			assign pif.word_out[gi*BW+BW-1]    = pif.gen ? par_bit : pif.word_in[gi*BW+BW-1];
			assign byte_ok[gi]                 = (^pif.word_in[gi*BW +: BW]) == pif.odd;
		end
	endgenerate

	assign pif.ok = &byte_ok;
endmodule : fpr_parity

// ### rtl/fpr_rst_seq.sv
// Device reset sequencer: counts port clock edges while reset is low, then arms and releases.
// Assumes port clock inputs are already reduced to one-cycle rise pulses.
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_rst_seq
	import fpr_pkg::*;
#(
	parameter int EDGES = `FPR_RST_EDGES
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic core_ce,
	input  wire logic dev_rst_low,
	input  wire logic a_rise,
	input  wire logic b_rise,
	output logic      load_pulse,
	output logic      ready
);
	generate
		if (EDGES < 1 || EDGES > 7) begin : g_bad
			$error("fpr_rst_seq: EDGES must be 1..7");
		end
	endgenerate

	localparam logic [2:0] EDGES_C = 3'(EDGES);

	fpr_rst_state_t state_reg, state_next;
	logic [2:0]     cnt_a_reg, cnt_b_reg;

	// Counts restart whenever reset is high, so a short pulse never completes
	wire       full_a    = cnt_a_reg >= EDGES_C;
	wire       full_b    = cnt_b_reg >= EDGES_C;
	wire [2:0] cnt_a_next = !dev_rst_low ? 3'h0 : (full_a ? cnt_a_reg : cnt_a_reg + 3'(a_rise));
	wire [2:0] cnt_b_next = !dev_rst_low ? 3'h0 : (full_b ? cnt_b_reg : cnt_b_reg + 3'(b_rise));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			FPR_RS_IDLE,
			FPR_RS_DONE: if (dev_rst_low && full_a && full_b) state_next = FPR_RS_ARMED;
			FPR_RS_ARMED: if (!dev_rst_low) state_next = FPR_RS_DONE;
			default: state_next = FPR_RS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg  <= FPR_RS_IDLE;
			cnt_a_reg  <= 3'h0;
			cnt_b_reg  <= 3'h0;
			load_pulse <= 1'b0;
			ready      <= 1'b0;
		end else if (core_ce) begin
			state_reg  <= state_next;
			cnt_a_reg  <= cnt_a_next;
			cnt_b_reg  <= cnt_b_next;
			load_pulse <= state_reg != FPR_RS_ARMED && state_next == FPR_RS_ARMED;
			ready      <= state_next == FPR_RS_DONE;
		end
	end

	property p_armed_counts;
		@(posedge core_clk) disable iff (!resetn)
		(state_reg == FPR_RS_ARMED) |-> (cnt_a_reg >= EDGES_C && cnt_b_reg >= EDGES_C);
	endproperty
	a_armed_counts: assert property (p_armed_counts) else $error("armed without enough edges");
endmodule : fpr_rst_seq

// ### rtl/fpr_port_ctrl.sv
// Port-side control for a dual-clock FIFO: read parity, direction, reset flags, offset latch.
// Assumes port pins are synchronous to core_clk and storage supplies mailbox and FIFO words.
//
// How it works
// - Port A mailbox read may generate parity
// - Port B reads may generate parity
// - Polarity input picks odd or even generation
// - Port A bytes are four nine-bit groups
// - Port B bytes are four nine-bit groups
// - Parity replaces each byte's top bit
// - Completed reset loads flag reset values
// - Reset rise latches the offset selects
// - Port A direction high writes, low reads
// - Port A outputs float while direction high
// - Port B direction high writes, low reads
// - Port B outputs float while direction high
// - Polarity high odd, low even
// - Transfers only on edges with enable high
// - Port B mailbox select picks output source
// - Port A mailbox generate forces error flag high
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_port_ctrl
	import fpr_pkg::*;
#(
	parameter int ADDR_W = `FPR_ADDR_W
) (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic              core_ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   irq,
	input  wire logic              flag_reset_n,
	input  wire logic              offset_select_high,
	input  wire logic              offset_select_low,
	input  wire logic              parity_odd_sel,
	input  wire logic              porta_clock,
	input  wire logic              porta_enable,
	input  wire logic              porta_dir_sel,
	input  wire logic              porta_mailbox_sel,
	input  wire logic              porta_parity_gen_sel,
	input  wire fpr_word_t         porta_data_bus_in,
	output fpr_word_t              porta_data_bus_out,
	output logic                   porta_data_bus_oe,
	output logic                   porta_parity_error_n,
	input  wire logic              portb_clock,
	input  wire logic              portb_enable,
	input  wire logic              portb_dir_sel,
	input  wire logic              portb_mailbox_sel,
	input  wire logic              portb_parity_gen_sel,
	input  wire fpr_word_t         portb_data_bus_in,
	output fpr_word_t              portb_data_bus_out,
	output logic                   portb_data_bus_oe,
	output logic                   portb_parity_error_n,
	input  wire fpr_word_t         a_to_b_mailbox,
	input  wire fpr_word_t         b_to_a_mailbox,
	input  wire fpr_word_t         fifo_out_data,
	output logic                   almost_full_flag,
	output logic                   almost_empty_flag,
	output logic                   empty_flag,
	output logic                   full_flag,
	output logic                   a_to_b_mailbox_flag,
	output logic                   b_to_a_mailbox_flag,
	output logic [1:0]             offset_select_reg,
	output logic                   device_ready
);
	generate
		if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad
			$error("fpr_port_ctrl: ADDR_W must be 4..32");
		end
	endgenerate

	// ****************************************
	// Port clock edges and transfer decode
	// ****************************************
	logic a_clk_prev_reg, b_clk_prev_reg;
	wire  a_rise  = porta_clock & ~a_clk_prev_reg;
	wire  b_rise  = portb_clock & ~b_clk_prev_reg;
	wire  a_read  = a_rise & porta_enable & ~porta_dir_sel;
	wire  b_read  = b_rise & portb_enable & ~portb_dir_sel;
	wire  a_write = a_rise & porta_enable & porta_dir_sel;
	wire  b_write = b_rise & portb_enable & portb_dir_sel;
	// Separate trees, yet a set-up mailbox read with generation still forces the A error flag high
	wire  a_setup = porta_enable & ~porta_dir_sel & porta_mailbox_sel & porta_parity_gen_sel;

	// ****************************************
	// Parity trees
	// ****************************************
	fpr_parity_if a_gen_if ();
	fpr_parity_if a_chk_if ();
	fpr_parity_if b_gen_if ();
	fpr_parity_if b_chk_if ();

	assign a_gen_if.word_in = b_to_a_mailbox;
	assign a_gen_if.odd     = parity_odd_sel;
	assign a_gen_if.gen     = porta_mailbox_sel & porta_parity_gen_sel;
	assign b_gen_if.word_in = portb_mailbox_sel ? a_to_b_mailbox : fifo_out_data;
	assign b_gen_if.odd     = parity_odd_sel;
	assign b_gen_if.gen     = portb_parity_gen_sel;
	assign a_chk_if.word_in = porta_data_bus_in;
	assign a_chk_if.odd     = parity_odd_sel;
	assign a_chk_if.gen     = 1'b0;
	assign b_chk_if.word_in = portb_data_bus_in;
	assign b_chk_if.odd     = parity_odd_sel;
	assign b_chk_if.gen     = 1'b0;

	fpr_parity #(.BYTES(`FPR_BYTES)) u_a_gen (.pif(a_gen_if.unit));
	fpr_parity #(.BYTES(`FPR_BYTES)) u_a_chk (.pif(a_chk_if.unit));
	fpr_parity #(.BYTES(`FPR_BYTES)) u_b_gen (.pif(b_gen_if.unit));
	fpr_parity #(.BYTES(`FPR_BYTES)) u_b_chk (.pif(b_chk_if.unit));

	wire a_err_n_next = a_setup | a_chk_if.ok;
	wire b_err_n_next = b_chk_if.ok;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			a_clk_prev_reg       <= 1'b0;
			b_clk_prev_reg       <= 1'b0;
			porta_data_bus_out   <= '0;
			portb_data_bus_out   <= '0;
			porta_data_bus_oe    <= 1'b0;
			portb_data_bus_oe    <= 1'b0;
			porta_parity_error_n <= 1'b1;
			portb_parity_error_n <= 1'b1;
		end else if (core_ce) begin
			a_clk_prev_reg       <= porta_clock;
			b_clk_prev_reg       <= portb_clock;
			if (a_read) porta_data_bus_out <= a_gen_if.word_out;
			if (b_read) portb_data_bus_out <= b_gen_if.word_out;
			porta_data_bus_oe    <= ~porta_dir_sel;
			portb_data_bus_oe    <= ~portb_dir_sel;
			porta_parity_error_n <= a_err_n_next;
			portb_parity_error_n <= b_err_n_next;
		end
	end

	// ****************************************
	// Device reset, flags and offset latch
	// ****************************************
	logic       ctrl_softrst_reg;
	logic       dev_rst_prev_reg;
	logic [5:0] flags_reg;
	logic       seq_load;
	wire        dev_rst_low = ~flag_reset_n | ctrl_softrst_reg;
	wire        rst_release = dev_rst_prev_reg & ~dev_rst_low;

	fpr_rst_seq #(.EDGES(`FPR_RST_EDGES)) u_rst_seq (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.core_ce     (core_ce),
		.dev_rst_low (dev_rst_low),
		.a_rise      (a_rise),
		.b_rise      (b_rise),
		.load_pulse  (seq_load),
		.ready       (device_ready)
	);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dev_rst_prev_reg  <= 1'b0;
			flags_reg         <= 6'h00;
			offset_select_reg <= 2'h0;
		end else if (core_ce) begin
			dev_rst_prev_reg <= dev_rst_low;
			if (seq_load) flags_reg <= `FPR_FLAGS_RST;
			if (rst_release) offset_select_reg <= {offset_select_high, offset_select_low};
		end
	end

	assign almost_full_flag    = flags_reg[0];
	assign almost_empty_flag   = flags_reg[1];
	assign empty_flag          = flags_reg[2];
	assign full_flag           = flags_reg[3];
	assign a_to_b_mailbox_flag = flags_reg[4];
	assign b_to_a_mailbox_flag = flags_reg[5];

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic                 aw_full_reg, w_full_reg;
	logic [ADDR_W-1:0]    awaddr_reg;
	logic [31:0]          wdata_reg;
	logic                 wstrb0_reg;
	logic [`FPR_IRQ_W-1:0] irq_st_reg, irq_mask_reg;

	wire aw_take    = s_axi_awvalid & s_axi_awready;
	wire w_take     = s_axi_wvalid & s_axi_wready;
	wire wr_do      = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	wire aw_next    = (aw_full_reg | aw_take) & ~wr_do;
	wire w_next     = (w_full_reg | w_take) & ~wr_do;
	wire ar_take    = s_axi_arvalid & s_axi_arready;
	wire rv_next    = (s_axi_rvalid & ~s_axi_rready) | ar_take;
	wire bv_next    = (s_axi_bvalid & ~s_axi_bready) | wr_do;
	wire [7:0] wa8  = 8'(awaddr_reg);
	wire [7:0] ra8  = 8'(s_axi_araddr);
	wire wa_ok      = awaddr_reg == ADDR_W'(wa8);
	wire ra_ok      = s_axi_araddr == ADDR_W'(ra8);
	wire wr_ctrl    = wr_do & wstrb0_reg & wa_ok & wa8 == `FPR_OFF_CTRL;
	wire wr_irq_st  = wr_do & wstrb0_reg & wa_ok & wa8 == `FPR_OFF_IRQ_ST;
	wire wr_mask    = wr_do & wstrb0_reg & wa_ok & wa8 == `FPR_OFF_IRQ_MASK;
	wire wr_hit     = wa_ok & (wa8 == `FPR_OFF_CTRL || wa8 == `FPR_OFF_STATUS ||
	                  wa8 == `FPR_OFF_IRQ_ST || wa8 == `FPR_OFF_IRQ_MASK);
	wire rd_ctrl    = ra_ok & ra8 == `FPR_OFF_CTRL;
	wire rd_status  = ra_ok & ra8 == `FPR_OFF_STATUS;
	wire rd_irq_st  = ra_ok & ra8 == `FPR_OFF_IRQ_ST;
	wire rd_mask    = ra_ok & ra8 == `FPR_OFF_IRQ_MASK;
	wire rd_hit     = rd_ctrl | rd_status | rd_irq_st | rd_mask;
	wire [31:0] status_word = {22'h00_0000, offset_select_reg, 1'b0, device_ready, flags_reg};
	wire [31:0] rd_word = rd_ctrl   ? {31'h0000_0000, ctrl_softrst_reg} :
	                      rd_status ? status_word :
	                      rd_irq_st ? {29'h0000_0000, irq_st_reg} :
	                      rd_mask   ? {29'h0000_0000, irq_mask_reg} : 32'h0000_0000;

	// ****************************************
	// Interrupts: sticky, write one to clear, set wins
	// ****************************************
	wire [`FPR_IRQ_W-1:0] irq_evt;
	assign irq_evt[`FPR_IRQ_RSTDONE] = seq_load;
	assign irq_evt[`FPR_IRQ_PERR_A]  = a_write & ~a_chk_if.ok;
	assign irq_evt[`FPR_IRQ_PERR_B]  = b_write & ~b_chk_if.ok;
	wire [`FPR_IRQ_W-1:0] irq_clr     = wr_irq_st ? wdata_reg[`FPR_IRQ_W-1:0] : '0;
	wire [`FPR_IRQ_W-1:0] irq_st_next = (irq_st_reg & ~irq_clr) | irq_evt;
	wire [`FPR_IRQ_W-1:0] mask_next   = wr_mask ? wdata_reg[`FPR_IRQ_W-1:0] : irq_mask_reg;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			awaddr_reg    <= '0;
			wdata_reg     <= 32'h0000_0000;
			wstrb0_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `FPR_RESP_OKAY;
		end else if (core_ce) begin
			aw_full_reg   <= aw_next;
			w_full_reg    <= w_next;
			s_axi_awready <= ~aw_next;
			s_axi_wready  <= ~w_next;
			s_axi_bvalid  <= bv_next;
			if (aw_take) awaddr_reg <= s_axi_awaddr;
			if (w_take) wdata_reg <= s_axi_wdata;
			if (w_take) wstrb0_reg <= s_axi_wstrb[0];
			if (wr_do) s_axi_bresp <= wr_hit ? `FPR_RESP_OKAY : `FPR_RESP_SLVERR;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `FPR_RESP_OKAY;
		end else if (core_ce) begin
			s_axi_arready <= ~rv_next;
			s_axi_rvalid  <= rv_next;
			if (ar_take) s_axi_rdata <= rd_word;
			if (ar_take) s_axi_rresp <= rd_hit ? `FPR_RESP_OKAY : `FPR_RESP_SLVERR;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_softrst_reg <= 1'b0;
			irq_st_reg       <= '0;
			irq_mask_reg     <= '0;
			irq              <= 1'b0;
		end else if (core_ce) begin
			if (wr_ctrl) ctrl_softrst_reg <= wdata_reg[`FPR_CTRL_SOFTRST];
			irq_st_reg   <= irq_st_next;
			irq_mask_reg <= mask_next;
			irq          <= |(irq_st_next & mask_next);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_a_gen;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && a_read && porta_mailbox_sel && porta_parity_gen_sel) |=>
		(^porta_data_bus_out[8:0]) == $past(parity_odd_sel) && (^porta_data_bus_out[35:27]) == $past(parity_odd_sel);
	endproperty
	a_a_gen: assert property (p_a_gen) else $error("port A mailbox parity wrong");

	property p_b_gen;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && b_read && portb_parity_gen_sel) |=>
		(^portb_data_bus_out[8:0]) == $past(parity_odd_sel) && (^portb_data_bus_out[17:9]) == $past(parity_odd_sel) &&
		(^portb_data_bus_out[26:18]) == $past(parity_odd_sel) && (^portb_data_bus_out[35:27]) == $past(parity_odd_sel);
	endproperty
	a_b_gen: assert property (p_b_gen) else $error("port B generated parity wrong");

	property p_a_plain;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && a_read && !porta_parity_gen_sel) |=> porta_data_bus_out == $past(b_to_a_mailbox);
	endproperty
	a_a_plain: assert property (p_a_plain) else $error("port A plain read altered");

	property p_b_mbox;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && b_read && portb_mailbox_sel && !portb_parity_gen_sel) |=> portb_data_bus_out == $past(a_to_b_mailbox);
	endproperty
	a_b_mbox: assert property (p_b_mbox) else $error("port B mailbox source wrong");

	property p_a_oe;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && porta_dir_sel) |=> !porta_data_bus_oe;
	endproperty
	a_a_oe: assert property (p_a_oe) else $error("port A drives while writing");

	property p_b_oe;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && portb_dir_sel) |=> !portb_data_bus_oe;
	endproperty
	a_b_oe: assert property (p_b_oe) else $error("port B drives while writing");

	property p_no_read;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && !a_read && !b_read) |=> $stable(porta_data_bus_out) && $stable(portb_data_bus_out);
	endproperty
	a_no_read: assert property (p_no_read) else $error("output changed without a read");

	property p_a_force;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && a_setup) |=> porta_parity_error_n;
	endproperty
	a_a_force: assert property (p_a_force) else $error("port A error flag not forced");

	property p_offset;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && rst_release) |=> offset_select_reg == $past({offset_select_high, offset_select_low});
	endproperty
	a_offset: assert property (p_offset) else $error("offset select not latched");

	property p_flags;
		@(posedge core_clk) disable iff (!resetn)
		(core_ce && seq_load) |=> almost_full_flag && a_to_b_mailbox_flag && b_to_a_mailbox_flag &&
		!empty_flag && !almost_empty_flag && !full_flag;
	endproperty
	a_flags: assert property (p_flags) else $error("reset flags wrong");
endmodule : fpr_port_ctrl

// ### sim/fpr_store_model.sv
// Storage-side stand-in: supplies mailbox and FIFO words to the port logic.
// Assumes the bench pulses load between port reads.
`timescale 1ns/1ps
module fpr_store_model
	import fpr_pkg::*;
(
	input  wire logic      core_clk,
	input  wire logic      load,
	input  wire fpr_word_t seed_word,
	output fpr_word_t      a_to_b_mailbox,
	output fpr_word_t      b_to_a_mailbox,
	output fpr_word_t      fifo_out_data
);
	// Three distinct words, so a wrong source select shows
	always_ff @(posedge core_clk) begin
		if (load) begin
			a_to_b_mailbox <= seed_word;
			b_to_a_mailbox <= ~seed_word;
			fifo_out_data  <= {seed_word[17:0], seed_word[35:18]};
		end
	end
endmodule : fpr_store_model

// ### sim/fifo_port_parity_reset_ctrl_bench.sv
// Self-checking bench for the port control block.
// Assumes the storage model above and a 100 MHz core clock.
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fifo_port_parity_reset_ctrl_bench;
	import fpr_pkg::*;
	logic core_clk = 0, resetn = 0, core_ce = 1, load = 0, irq, device_ready;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, offset_select_reg, rr;
	logic flag_reset_n = 1, offset_select_high = 0, offset_select_low = 0, parity_odd_sel = 0;
	logic porta_clock = 0, porta_enable = 0, porta_dir_sel = 1, porta_mailbox_sel = 0, porta_parity_gen_sel = 0;
	logic portb_clock = 0, portb_enable = 0, portb_dir_sel = 1, portb_mailbox_sel = 0, portb_parity_gen_sel = 0;
	logic porta_data_bus_oe, porta_parity_error_n, portb_data_bus_oe, portb_parity_error_n;
	logic almost_full_flag, almost_empty_flag, empty_flag, full_flag, a_to_b_mailbox_flag, b_to_a_mailbox_flag;
	fpr_word_t porta_data_bus_in, portb_data_bus_in, porta_data_bus_out, portb_data_bus_out;
	fpr_word_t a_to_b_mailbox, b_to_a_mailbox, fifo_out_data, seed_word = 0, a_drv = 0, b_drv = 0;
	logic [63:0] w;
	int seed = 60104, fail_count = 0, comparisons = 0, i, n;

	// ****************************************
	// Wiring
	// ****************************************
	// Shared bus lines carry the device's value while it drives
	assign porta_data_bus_in = porta_data_bus_oe ? porta_data_bus_out : a_drv;
	assign portb_data_bus_in = portb_data_bus_oe ? portb_data_bus_out : b_drv;
	fpr_port_ctrl dut_u (.*);
	fpr_store_model store_u (.*);
	always #5 core_clk = ~core_clk;

	function automatic fpr_word_t gen_par(fpr_word_t x, logic odd);
		fpr_word_t r;
		r = x;
		for (int k = 0; k < 4; k++) r[9*k+8] = ^x[9*k+:8] ^ odd;
		return r;
	endfunction : gen_par

	function automatic fpr_word_t exp_rd(fpr_word_t x, logic gen);
		return gen ? gen_par(x, parity_odd_sel) : x;
	endfunction : exp_rd

	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test

	task automatic wait_out(input int k);
		if (k >= 50) begin
			fail_count++;
			$display("ERROR %0t bus wait ran out", $time);
			stop_test();
		end
	endtask : wait_out

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
			if (s_axi_bvalid === 1'b1) break;
		end
		rr = s_axi_bresp;
		s_axi_bready <= 0;
		wait_out(n);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
			if (s_axi_rvalid === 1'b1) break;
		end
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		wait_out(n);
	endtask : axi_rd

	// Port clocks stand low between single pulses, slow against core_clk
	task automatic pedge(input logic b);
		repeat (2) @(posedge core_clk);
		if (b) portb_clock <= 1;
		else porta_clock <= 1;
		repeat (3) @(posedge core_clk);
		porta_clock <= 0;
		portb_clock <= 0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : pedge

	task automatic reload(input fpr_word_t x);
		@(posedge core_clk);
		seed_word <= x;
		load <= 1;
		@(posedge core_clk);
		load <= 0;
	endtask : reload

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1;
		flag_reset_n <= 0;
		offset_select_high <= 1;
		for (i = 0; i < 4; i++) pedge(0);
		for (i = 0; i < 3; i++) pedge(1);
		check({35'h0, almost_full_flag}, 36'h0);
		pedge(1);
		check({30'h0, b_to_a_mailbox_flag, a_to_b_mailbox_flag, full_flag, empty_flag,
			almost_empty_flag, almost_full_flag}, {30'h0, `FPR_FLAGS_RST});
		flag_reset_n <= 1;
		repeat (4) @(posedge core_clk);
		offset_select_high <= 0;
		offset_select_low <= 1;
		repeat (2) @(posedge core_clk);
		#1;
		check({34'h0, offset_select_reg}, 36'h2);
		check({35'h0, device_ready}, 36'h1);
		porta_dir_sel <= 0;
		portb_dir_sel <= 0;
		porta_enable <= 1;
		portb_enable <= 1;
		for (i = 0; i < 12; i++) begin
			w = {$random(seed), $random(seed)};
			reload(w[35:0]);
			parity_odd_sel <= w[36];
			porta_mailbox_sel <= w[37] | (i == 0);
			porta_parity_gen_sel <= w[38] | (i == 0);
			portb_mailbox_sel <= w[39];
			portb_parity_gen_sel <= w[40] | (i == 1);
			pedge(0);
			pedge(1);
			check(porta_data_bus_out, exp_rd(b_to_a_mailbox, porta_mailbox_sel & porta_parity_gen_sel));
			check(portb_data_bus_out, exp_rd(portb_mailbox_sel ? a_to_b_mailbox : fifo_out_data,
				portb_parity_gen_sel));
			check({35'h0, porta_data_bus_oe}, 36'h1);
		end
		w[35:0] = porta_data_bus_out;
		porta_enable <= 0;
		portb_dir_sel <= 1;
		a_drv <= gen_par(w[63:28], ~parity_odd_sel);
		b_drv <= gen_par(w[63:28], ~parity_odd_sel);
		reload(~seed_word);
		pedge(0);
		check(porta_data_bus_out, w[35:0]);
		check({35'h0, portb_data_bus_oe}, 36'h0);
		check({35'h0, portb_parity_error_n}, 36'h0);
		porta_enable <= 1;
		porta_dir_sel <= 1;
		pedge(0);
		check(porta_data_bus_out, w[35:0]);
		check({35'h0, porta_data_bus_oe}, 36'h0);
		check({35'h0, porta_parity_error_n}, 36'h0);
		// Bus still carries the bad word for one cycle, so only forcing keeps the flag high
		porta_dir_sel <= 0;
		porta_mailbox_sel <= 1;
		porta_parity_gen_sel <= 1;
		@(posedge core_clk);
		#1;
		check({35'h0, porta_parity_error_n}, 36'h1);
		core_ce <= 0;
		pedge(0);
		core_ce <= 1;
		check(porta_data_bus_out, w[35:0]);
		axi_rd(`FPR_OFF_IRQ_ST);
		check({34'h0, rd[1:0]}, 36'h3);
		check({35'h0, irq}, 36'h0);
		axi_wr(`FPR_OFF_IRQ_MASK, 32'h0000_0002);
		check({34'h0, rr}, {34'h0, `FPR_RESP_OKAY});
		repeat (2) @(posedge core_clk);
		check({35'h0, irq}, 36'h1);
		axi_wr(`FPR_OFF_IRQ_ST, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		check({35'h0, irq}, 36'h0);
		axi_rd(8'h40);
		check({34'h0, rr}, {34'h0, `FPR_RESP_SLVERR});
		// Short soft reset: no port edges, so nothing reloads, but the release latches again
		axi_wr(`FPR_OFF_CTRL, 32'h0000_0001);
		axi_wr(`FPR_OFF_CTRL, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		#1;
		check({34'h0, offset_select_reg}, 36'h1);
		check({35'h0, device_ready}, 36'h1);
		stop_test();
	end
endmodule : fifo_port_parity_reset_ctrl_bench
